// *** core/moc_regs.svh ***
// Register offsets, field positions and reset values of the option block
`ifndef MOC_REGS_SVH
`define MOC_REGS_SVH

`define MOC_ADDR_W            4
`define MOC_OFF_OPTION        4'h0
`define MOC_OFF_STATUS        4'h4

`define MOC_BIT_PAGE_ONE      7
`define MOC_BIT_PAGE_ZERO     6
`define MOC_BIT_SPARE         2
`define MOC_BIT_LOCK          1
`define MOC_BIT_IRQ_LEVEL     3

`define MOC_RST_PAGE_ZERO     1'b0
`define MOC_RST_PAGE_ONE      1'b0
`define MOC_RST_IRQ_LEVEL     1'b1
`define MOC_RST_FIRST_WR      1'b0
`define MOC_RST_LOCK          1'b0

`define MOC_CPU_ADDR_W        16
`define MOC_P0_LO             16'h0020
`define MOC_P0_RES_HI         16'h002F
`define MOC_P0_RAM_LO         16'h0030
`define MOC_P0_RAM_BYTES      16'h0020
`define MOC_P0_ROM_HI         16'h005F
`define MOC_P1_LO             16'h0100
`define MOC_P1_BYTES          16'h0060

`endif

// *** core/moc_pkg.sv ***
// Types shared by the memory option block
package moc_pkg;
  typedef enum logic [1:0]
  {
    MOC_MAP_NONE,
    MOC_MAP_RAM,
    MOC_MAP_ROM,
    MOC_MAP_RESERVED
  } moc_map_type;

  typedef enum logic
  {
    MOC_BUS_IDLE,
    MOC_BUS_DONE
  } moc_bus_type;
endpackage : moc_pkg

// *** core/moc_option.sv ***
// Memory option register, address map select and interrupt sense logic
// Operation
// - Page zero RAM: 32 bytes at 0030, 0020-002F reserved
// - Page zero clear: program memory 0020-005F
// - Page one RAM: 96 bytes at 0100
// - RAM selects read/write anytime, decode follows immediately; here cpu_map is registered and follows one cycle later
// - Lock bit non-volatile, unchanged by reset
// - Lock set blocks bootloader, single-chip only
// - Sense bit set by reset, first write only
// - Sense set: edge and low level; else edge
// - Bits 5, 4, 0 read zero
// - Bit 2 keeps value across reset
//
// Our own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "moc_regs.svh"

module moc_option
  import moc_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic [`MOC_ADDR_W-1:0]      avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [31:0]                 avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        lock_load,
  input  wire logic                        lock_load_value,
  input  wire logic [`MOC_CPU_ADDR_W-1:0]  cpu_addr,
  input  wire logic                        irq_pin_n,
  output logic      [1:0]                  cpu_map,
  output logic                             bootloader_allow,
  output logic                             single_chip_only,
  output logic                             irq_request
);

  logic        page_zero_ram_select_q;
  logic        page_one_ram_select_q;
  logic        irq_level_q;
  logic        irq_first_done_q;
  logic        spare_q;
  logic        bootloader_lock_q;
  logic        irq_pin_prev_q;
  moc_bus_type bus_q;
  moc_bus_type bus_d;

  logic        bus_req;
  logic        bus_take;
  logic        sel_option;
  logic        sel_status;
  logic        option_wr;
  logic        first_wr;
  logic [7:0]  option_src;
  logic [7:0]  option_used;
  logic [7:0]  option_value;
  logic [31:0] status_value;
  logic [31:0] readdata_d;

  moc_map_type map_d;
  logic        in_p0_res;
  logic        in_p0_ram;
  logic        in_p0_rom;
  logic        in_p1;
  logic        irq_edge;
  logic        irq_level_hit;
  logic        irq_d;

  assign bus_req    = avs_read | avs_write;
  assign bus_take   = (bus_q == MOC_BUS_IDLE) & bus_req;
  assign sel_option = (avs_address == `MOC_OFF_OPTION);
  assign sel_status = (avs_address == `MOC_OFF_STATUS);
  assign option_wr  = bus_take & avs_write & avs_byteenable[0] & sel_option;
  assign first_wr   = option_wr & ~irq_first_done_q;

  // One wait cycle per access, then completion
  always_comb
  begin
    bus_d = MOC_BUS_IDLE;
    case (bus_q)
      MOC_BUS_IDLE:
      begin
        if (bus_req)
          bus_d = MOC_BUS_DONE;
      end
      MOC_BUS_DONE:
      begin
        bus_d = MOC_BUS_IDLE;
      end
      default:
      begin
        bus_d = MOC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bus_q <= MOC_BUS_IDLE;
    end
    else
    begin
      bus_q <= bus_d;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= ~bus_take;
    end
  end

  // Source of each option bit
  always_comb
  begin
    option_src = 8'h00;
    option_src[`MOC_BIT_PAGE_ONE]  = page_one_ram_select_q;
    option_src[`MOC_BIT_PAGE_ZERO] = page_zero_ram_select_q;
    option_src[`MOC_BIT_IRQ_LEVEL] = irq_level_q;
    option_src[`MOC_BIT_SPARE]     = spare_q;
    option_src[`MOC_BIT_LOCK]      = bootloader_lock_q;
  end

  // Positions that exist; the rest read zero and ignore writes
  always_comb
  begin
    option_used = 8'h00;
    option_used[`MOC_BIT_PAGE_ONE]  = 1'b1;
    option_used[`MOC_BIT_PAGE_ZERO] = 1'b1;
    option_used[`MOC_BIT_IRQ_LEVEL] = 1'b1;
    option_used[`MOC_BIT_SPARE]     = 1'b1;
    option_used[`MOC_BIT_LOCK]      = 1'b1;
  end

  generate
    for (genvar gi = 0; gi < 8; gi++)
    begin : g_option_bit
      assign option_value[gi] = option_used[gi] & option_src[gi];
    end
  endgenerate

  always_comb
  begin
    status_value    = 32'h00000000;
    status_value[1] = irq_first_done_q;
    status_value[0] = irq_pin_prev_q;
  end

  always_comb
  begin
    readdata_d = 32'h00000000;
    if (sel_option)
      readdata_d = {24'h000000, option_value};
    else if (sel_status)
      readdata_d = status_value;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      avs_readdata <= 32'h00000000;
    end
    else if (bus_take && avs_read)
    begin
      avs_readdata <= readdata_d;
    end
  end

  // Page zero select: writable at any time
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      page_zero_ram_select_q <= `MOC_RST_PAGE_ZERO;
    end
    else if (option_wr)
    begin
      page_zero_ram_select_q <= avs_writedata[`MOC_BIT_PAGE_ZERO];
    end
  end

  // Page one select: writable at any time
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      page_one_ram_select_q <= `MOC_RST_PAGE_ONE;
    end
    else if (option_wr)
    begin
      page_one_ram_select_q <= avs_writedata[`MOC_BIT_PAGE_ONE];
    end
  end

  // Sense bit: set by reset, cleared only by the first write
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_level_q <= `MOC_RST_IRQ_LEVEL;
    end
    else if (first_wr)
    begin
      irq_level_q <= irq_level_q & avs_writedata[`MOC_BIT_IRQ_LEVEL];
    end
  end

  // Marks that the one allowed sense write has been used
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_first_done_q <= `MOC_RST_FIRST_WR;
    end
    else if (first_wr)
    begin
      irq_first_done_q <= 1'b1;
    end
  end

  // Spare bit is plain storage untouched by reset
  always_ff @(posedge clock)
  begin
    if (option_wr)
    begin
      spare_q <= avs_writedata[`MOC_BIT_SPARE];
    end
  end

  // Lock cell: only the programming load changes it, never reset
  always_ff @(posedge clock)
  begin
    if (lock_load)
    begin
      bootloader_lock_q <= lock_load_value;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      bootloader_allow <= 1'b0;
    end
    else
    begin
      bootloader_allow <= ~bootloader_lock_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      single_chip_only <= 1'b1;
    end
    else
    begin
      single_chip_only <= bootloader_lock_q;
    end
  end

  // Address windows of the selectable areas
  assign in_p0_res = (cpu_addr >= `MOC_P0_LO) &&
                     (cpu_addr <= `MOC_P0_RES_HI);
  assign in_p0_ram = (cpu_addr >= `MOC_P0_RAM_LO) &&
                     (cpu_addr < `MOC_P0_RAM_LO + `MOC_P0_RAM_BYTES);
  assign in_p0_rom = (cpu_addr >= `MOC_P0_LO) &&
                     (cpu_addr <= `MOC_P0_ROM_HI);
  assign in_p1     = (cpu_addr >= `MOC_P1_LO) &&
                     (cpu_addr < `MOC_P1_LO + `MOC_P1_BYTES);

  always_comb
  begin
    map_d = MOC_MAP_NONE;
    if (in_p1)
      map_d = page_one_ram_select_q ? MOC_MAP_RAM : MOC_MAP_ROM;
    else if (page_zero_ram_select_q)
    begin
      if (in_p0_res)
        map_d = MOC_MAP_RESERVED;
      else if (in_p0_ram)
        map_d = MOC_MAP_RAM;
    end
    else if (in_p0_rom)
      map_d = MOC_MAP_ROM;
  end

  // Decode output is registered and follows the select bits one cycle later
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cpu_map <= MOC_MAP_NONE;
    end
    else
    begin
      cpu_map <= map_d;
    end
  end

  // External interrupt sense
  assign irq_edge      = irq_pin_prev_q & ~irq_pin_n;
  assign irq_level_hit = irq_level_q & ~irq_pin_n;
  assign irq_d         = irq_edge | irq_level_hit;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_pin_prev_q <= 1'b1;
    end
    else
    begin
      irq_pin_prev_q <= irq_pin_n;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_request <= 1'b0;
    end
    else
    begin
      irq_request <= irq_d;
    end
  end

endmodule : moc_option

`default_nettype wire

// *** tb/moc_option_sva.sv ***
// Port assertions for the memory option block
`timescale 1ns/1ps
`default_nettype none
module moc_option_sva
  import moc_pkg::*;
(
  input wire logic        clock,
  input wire logic        srst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        lock_load,
  input wire logic        lock_load_value,
  input wire logic [15:0] cpu_addr,
  input wire logic        irq_pin_n,
  input wire logic [1:0]  cpu_map,
  input wire logic        bootloader_allow,
  input wire logic        single_chip_only,
  input wire logic        irq_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  p0_low_a: assert property (!srst && cpu_addr[15:4] == 12'h002
    |=> cpu_map inside {MOC_MAP_ROM, MOC_MAP_RESERVED}) else $error("p0 low");
  p0_ram_a: assert property (!srst && cpu_addr inside {[16'h30:16'h4F]}
    |=> cpu_map inside {MOC_MAP_RAM, MOC_MAP_ROM}) else $error("p0 ram");
  p1_map_a: assert property (!srst && cpu_addr inside {[16'h100:16'h15F]}
    |=> cpu_map inside {MOC_MAP_RAM, MOC_MAP_ROM}) else $error("p1 map");
  lock_out_a: assert property (bootloader_allow ^ single_chip_only)
    else $error("lock outputs");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low");
  bus_ans_a: assert property ($rose(avs_read | avs_write) |=>
    !avs_waitrequest) else $error("bus answer");
  unused_zero_a: assert property (!avs_waitrequest && avs_read &&
    avs_address == 4'h0 |-> avs_readdata[5:4] == 2'h0 && !avs_readdata[0])
    else $error("unused bits");
  irq_edge_a: assert property ($fell(irq_pin_n) |-> ##[1:2] irq_request)
    else $error("irq edge");
  cover property (cpu_map == MOC_MAP_RESERVED);
  cover property (irq_request && !irq_pin_n);
  cover property (avs_write && !avs_waitrequest);
endmodule : moc_option_sva
bind moc_option moc_option_sva moc_option_sva_inst (.clock, .srst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .lock_load, .lock_load_value, .cpu_addr,
  .irq_pin_n, .cpu_map, .bootloader_allow, .single_chip_only, .irq_request);
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the memory option block
`timescale 1ns/1ps
`default_nettype none
module tb
  import moc_pkg::*;
;
  logic        clock, srst, avs_read, avs_write, lock_load, lock_load_value;
  logic        irq_pin_n, avs_waitrequest, bootloader_allow;
  logic        single_chip_only, irq_request;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] cpu_addr;
  logic [1:0]  cpu_map;
  int          n_errors, compares, cyc;
  moc_option moc_option_inst (.clock, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .lock_load, .lock_load_value, .cpu_addr, .irq_pin_n,
    .cpu_map, .bootloader_allow, .single_chip_only, .irq_request);
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task end_sim;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clock);
  endtask : bus
  task map(input logic [15:0] a, input moc_map_type e);
    cpu_addr <= a;
    repeat (2) @(posedge clock);
    chk(cpu_map, e);
  endtask : map
  task ld(input logic v);
    lock_load       <= 1'b1;
    lock_load_value <= v;
    @(posedge clock);
    lock_load <= 1'b0;
    repeat (2) @(posedge clock);
    chk({bootloader_allow, single_chip_only}, {!v, v});
  endtask : ld
  task rst_pulse;
    cpu_addr <= 16'h0000;
    srst     <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
  endtask : rst_pulse
  task t_sense;
    irq_pin_n <= 1'b0;
    repeat (5) @(posedge clock);
    chk(irq_request, 1'b1);
    bus(1'b1, 4'h0, 32'h00);
    bus(1'b1, 4'h0, 32'h08);
    bus(1'b0, 4'h0, 32'h00);
    chk(rd & 32'hFB, 32'h02);
    irq_pin_n <= 1'b1;
    repeat (2) @(posedge clock);
    irq_pin_n <= 1'b0;
    repeat (5) @(posedge clock);
    chk(irq_request, 1'b0);
    irq_pin_n <= 1'b1;
  endtask : t_sense
  task t_map;
    bus(1'b1, 4'h0, 32'hFF);
    bus(1'b0, 4'h0, 32'h00);
    chk(rd, 32'hC6);
    map(16'h0020, MOC_MAP_RESERVED);
    map(16'h002F, MOC_MAP_RESERVED);
    map(16'h0030, MOC_MAP_RAM);
    map(16'h004F, MOC_MAP_RAM);
    map(16'h0050, MOC_MAP_NONE);
    map(16'h015F, MOC_MAP_RAM);
    bus(1'b1, 4'h0, 32'h04);
    map(16'h0020, MOC_MAP_ROM);
    map(16'h005F, MOC_MAP_ROM);
    map(16'h0100, MOC_MAP_ROM);
    avs_byteenable <= 4'h0;
    bus(1'b1, 4'h0, 32'hFF);
    avs_byteenable <= 4'h1;
    bus(1'b0, 4'h0, 32'h00);
    chk(rd, 32'h06);
    bus(1'b0, 4'h4, 32'h00);
    chk(rd, 32'h03);
    bus(1'b0, 4'h8, 32'h00);
    chk(rd, 32'h00);
  endtask : t_map
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      end_sim;
    end
  end
  initial
  begin
    {srst, avs_read, avs_write, lock_load, lock_load_value} = 5'h12;
    avs_byteenable = 4'h1;
    {avs_address, avs_writedata, cpu_addr} = '0;
    irq_pin_n = 1'b1;
    {n_errors, compares, cyc} = '0;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    ld(1'b1);
    t_sense;
    t_map;
    rst_pulse;
    bus(1'b0, 4'h0, 32'h00);
    chk(rd, 32'h0E);
    ld(1'b0);
    end_sim;
  end
endmodule : tb
`default_nettype wire
